// ---- core/ppb_regs_pkg.sv ----
// Constants and types of the bus performance, power control and burst count registers
// Functional notes
// - Read latency cycles, from request to completion, are summed in a 16-bit field.
// - Double words moved by our own bus-master transfers are summed in an 8-bit field.
// - Reading the performance counter returns both sums and clears them.
// - The wake flag is set on every wake event, whatever the wake signal enable holds.
// - Writing one to the wake flag clears it and releases PME#; writing zero does nothing.
// - PME# is driven only while the wake signal enable bit is set.
// - A two-bit power state field reads and sets D0 to D3hot, resetting to D0.
// - A write of an unsupported power state completes but leaves the state unchanged.
// - The data scale and data select fields read as zero and ignore writes.
// - A five-bit threshold, reset to 5, sets how many good bursts raise transmit done.
package ppb_regs_pkg;

	// ---------------------------------------------
	// Register map
	// ---------------------------------------------
	localparam logic [7:0] PPB_OFS_PERF = 8'h8C;
	localparam logic [7:0] PPB_OFS_TX_BURST_COUNT_TIMEOUT = 8'h9C;
	localparam logic [7:0] PPB_OFS_PWR = 8'hE0;

	// ---------------------------------------------
	// Field layout
	// ---------------------------------------------
	localparam int PPB_CLK_LSB = 16;
	localparam int PPB_CLK_W = 16;
	localparam int PPB_DW_LSB = 0;
	localparam int PPB_DW_W = 8;
	localparam int PPB_WAKE_FLAG_BIT = 15;
	localparam int PPB_WAKE_EN_BIT = 8;
	localparam int PPB_PSTATE_LSB = 0;
	localparam int PPB_PSTATE_W = 2;
	localparam int PPB_TX_BURST_THRESHOLD_LSB = 16;
	localparam int PPB_TX_BURST_THRESHOLD_W = 5;

	// ---------------------------------------------
	// Reset values and support
	// ---------------------------------------------
	localparam logic [4:0] PPB_TX_BURST_THRESHOLD_RST = 5'h05;
	localparam logic [1:0] PPB_PSTATE_RST = 2'h0;
	// One bit per state D0..D3hot; D1 and D2 not supported
	localparam logic [3:0] PPB_PSTATE_SUPPORT = 4'h9;
	localparam logic [15:0] PPB_CLK_MAX = 16'hFFFF;
	localparam logic [7:0] PPB_DW_MAX = 8'hFF;

	typedef enum logic [1:0] {PPB_D0, PPB_D1, PPB_D2, PPB_D3HOT} ppb_pstate_e;

	// ---------------------------------------------
	// Carriers
	// ---------------------------------------------
	typedef struct packed {
		logic rd_req;
		logic rd_done;
		logic dword;
	} ppb_bus_evt_s;

	typedef struct packed {
		logic burst_ok;
		logic burst_fail;
	} ppb_tx_evt_s;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} ppb_csr_req_s;

	typedef struct packed {
		logic busy;
		logic [15:0] clk_total;
		logic [7:0] dw_total;
		logic wake_flag;
		logic wake_en;
		ppb_pstate_e pstate;
		logic [4:0] tb_thresh;
		logic [4:0] tb_count;
		logic tx_done;
		logic pme_oe;
		logic ack;
		logic [31:0] rdata;
	} ppb_state_s;

endpackage

// ---- core/ppb_regs.sv ----
// Performance counter, power control/status and transmit burst count registers
module ppb_regs
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input ppb_regs_pkg::ppb_csr_req_s csr_req_i,
	input ppb_regs_pkg::ppb_bus_evt_s bus_evt_i,
	input ppb_regs_pkg::ppb_tx_evt_s tx_evt_i,
	input wire logic wake_event_i,
	output logic [31:0] csr_rdata_o,
	output logic csr_ack_o,
	output logic tx_done_irq_o,
	output logic pme_n_o,
	output logic pme_oe_o,
	output logic [1:0] power_state_o
);
	import ppb_regs_pkg::*;

	ppb_state_s state_reg;
	ppb_state_s state_next;

	logic hit_perf;
	logic hit_pwr;
	logic hit_tx_burst_count_timeout;
	logic rd_active;
	logic [1:0] wr_state;

	assign hit_perf = csr_req_i.addr == PPB_OFS_PERF;
	assign hit_pwr = csr_req_i.addr == PPB_OFS_PWR;
	assign hit_tx_burst_count_timeout = csr_req_i.addr == PPB_OFS_TX_BURST_COUNT_TIMEOUT;
	assign rd_active = bus_evt_i.rd_req | state_reg.busy;
	assign wr_state = csr_req_i.wdata[PPB_PSTATE_LSB +: PPB_PSTATE_W];

	// ---------------------------------------------
	// Next state
	// ---------------------------------------------
	always_comb
	begin
		state_next = state_reg;
		state_next.ack = 1'b0;
		state_next.tx_done = 1'b0;
		// Request cycle through completion cycle are all counted
		state_next.busy = rd_active & ~bus_evt_i.rd_done;

		// Read snapshot first, so a clear never loses the reported value
		if (csr_req_i.rd)
		begin
			state_next.ack = 1'b1;
			state_next.rdata = 32'h0000_0000;
			if (hit_perf)
			begin
				state_next.rdata[PPB_CLK_LSB +: PPB_CLK_W] = state_reg.clk_total;
				state_next.rdata[PPB_DW_LSB +: PPB_DW_W] = state_reg.dw_total;
				state_next.clk_total = 16'h0000;
				state_next.dw_total = 8'h00;
			end
			else if (hit_pwr)
			begin
				// Scale and select stay zero from the cleared word
				state_next.rdata[PPB_WAKE_FLAG_BIT] = state_reg.wake_flag;
				state_next.rdata[PPB_WAKE_EN_BIT] = state_reg.wake_en;
				state_next.rdata[PPB_PSTATE_LSB +: PPB_PSTATE_W] = state_reg.pstate;
			end
			else if (hit_tx_burst_count_timeout)
			begin
				state_next.rdata[PPB_TX_BURST_THRESHOLD_LSB +: PPB_TX_BURST_THRESHOLD_W] = state_reg.tb_thresh;
			end
		end

		// Increments applied after the clear: an event in the read cycle survives
		if (rd_active && state_next.clk_total != PPB_CLK_MAX)
		begin
			state_next.clk_total = state_next.clk_total + 16'h0001;
		end
		if (bus_evt_i.dword && state_next.dw_total != PPB_DW_MAX)
		begin
			state_next.dw_total = state_next.dw_total + 8'h01;
		end

		if (csr_req_i.wr)
		begin
			state_next.ack = 1'b1;
			if (hit_pwr)
			begin
				if (csr_req_i.wdata[PPB_WAKE_FLAG_BIT])
				begin
					state_next.wake_flag = 1'b0;
				end
				state_next.wake_en = csr_req_i.wdata[PPB_WAKE_EN_BIT];
				if (PPB_PSTATE_SUPPORT[wr_state])
				begin
					state_next.pstate = ppb_pstate_e'(wr_state);
				end
			end
			else if (hit_tx_burst_count_timeout)
			begin
				state_next.tb_thresh = csr_req_i.wdata[PPB_TX_BURST_THRESHOLD_LSB +: PPB_TX_BURST_THRESHOLD_W];
			end
		end

		// Set wins over the write-one clear
		if (wake_event_i)
		begin
			state_next.wake_flag = 1'b1;
		end
		state_next.pme_oe = state_next.wake_flag & state_next.wake_en;

		// A failed burst breaks the consecutive run
		if (tx_evt_i.burst_fail)
		begin
			state_next.tb_count = 5'h00;
		end
		else if (tx_evt_i.burst_ok)
		begin
			// Threshold of zero behaves as one: every good burst signals
			if (state_reg.tb_count + 5'h01 >= state_reg.tb_thresh)
			begin
				state_next.tb_count = 5'h00;
				state_next.tx_done = 1'b1;
			end
			else
			begin
				state_next.tb_count = state_reg.tb_count + 5'h01;
			end
		end
	end

	// ---------------------------------------------
	// State register
	// ---------------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_reg <= '0;
			state_reg.pstate <= PPB_D0;
			state_reg.tb_thresh <= PPB_TX_BURST_THRESHOLD_RST;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// ---------------------------------------------
	// Outputs
	// ---------------------------------------------
	assign csr_rdata_o = state_reg.rdata;
	assign csr_ack_o = state_reg.ack;
	assign tx_done_irq_o = state_reg.tx_done;
	// Open drain: only ever pulls low
	assign pme_n_o = 1'b0;
	assign pme_oe_o = state_reg.pme_oe;
	assign power_state_o = state_reg.pstate;

	// ---------------------------------------------
	// Checks
	// ---------------------------------------------
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	AST_PERF_CLEAR: assert property (
		(csr_req_i.rd && hit_perf && !rd_active && !bus_evt_i.dword)
		|=> (state_reg.clk_total == 16'h0000 && state_reg.dw_total == 8'h00))
		else $error("perf counter not cleared by read");

	AST_PERF_SNAPSHOT: assert property (
		(csr_req_i.rd && hit_perf)
		|=> (csr_rdata_o[31:16] == $past(state_reg.clk_total)
		&& csr_rdata_o[7:0] == $past(state_reg.dw_total) && csr_ack_o))
		else $error("perf read returned wrong counts");

	AST_CLK_COUNT: assert property (
		(!csr_req_i.rd && rd_active && state_reg.clk_total != PPB_CLK_MAX)
		|=> state_reg.clk_total == $past(state_reg.clk_total) + 16'h0001)
		else $error("read latency cycle not counted");

	AST_DW_COUNT: assert property (
		(!csr_req_i.rd && !bus_evt_i.dword) |=> $stable(state_reg.dw_total))
		else $error("dword total moved without a dword");

	AST_SATURATE: assert property (
		(state_reg.dw_total == PPB_DW_MAX && !(csr_req_i.rd && hit_perf))
		|=> state_reg.dw_total == PPB_DW_MAX)
		else $error("dword total wrapped");

	AST_WAKE_SET: assert property (
		wake_event_i |=> state_reg.wake_flag)
		else $error("wake event not flagged");

	AST_WAKE_CLEAR: assert property (
		(csr_req_i.wr && hit_pwr && csr_req_i.wdata[15] && !wake_event_i)
		|=> (!state_reg.wake_flag && !pme_oe_o))
		else $error("write one did not clear wake flag");

	AST_PME_GATED: assert property (
		pme_oe_o |-> (state_reg.wake_en && state_reg.wake_flag))
		else $error("PME driven while disabled");

	AST_PSTATE_KEEP: assert property (
		(csr_req_i.wr && hit_pwr && !PPB_PSTATE_SUPPORT[wr_state]) |=> $stable(power_state_o))
		else $error("unsupported power state accepted");

	AST_PWR_ZERO: assert property (
		(csr_req_i.rd && hit_pwr) |=> csr_rdata_o[14:9] == 6'h00)
		else $error("data scale or select not zero");

	AST_TX_DONE: assert property (
		tx_done_irq_o |-> ($past(tx_evt_i.burst_ok) && !$past(tx_evt_i.burst_fail)))
		else $error("transmit done without a good burst");

	// ---------------------------------------------
	// Register bus checks
	// ---------------------------------------------
	AST_ACK_GIVEN: assert property (
		(csr_req_i.rd || csr_req_i.wr) |=> csr_ack_o)
		else $error("access not acknowledged");

	AST_ACK_IDLE: assert property (
		!(csr_req_i.rd || csr_req_i.wr) |=> !csr_ack_o)
		else $error("acknowledge without an access");

	AST_RDATA_HOLD: assert property (
		!csr_req_i.rd |=> $stable(csr_rdata_o))
		else $error("read data moved without a read");

	AST_PERF_RSVD: assert property (
		(csr_req_i.rd && hit_perf) |=> csr_rdata_o[15:8] == 8'h00)
		else $error("perf reserved bits not zero");

	// ---------------------------------------------
	// Counter checks
	// ---------------------------------------------
	AST_CLK_IDLE: assert property (
		(!csr_req_i.rd && !rd_active) |=> $stable(state_reg.clk_total))
		else $error("clock total moved with no read open");

	AST_BUSY_END: assert property (
		bus_evt_i.rd_done |=> !state_reg.busy)
		else $error("read access still open after completion");

	AST_DW_STEP: assert property (
		(!csr_req_i.rd && bus_evt_i.dword && state_reg.dw_total != PPB_DW_MAX)
		|=> state_reg.dw_total == $past(state_reg.dw_total) + 8'h01)
		else $error("dword not counted");

	AST_CLK_SATURATE: assert property (
		(state_reg.clk_total == PPB_CLK_MAX && !(csr_req_i.rd && hit_perf))
		|=> state_reg.clk_total == PPB_CLK_MAX)
		else $error("clock total wrapped");

	// ---------------------------------------------
	// Power checks
	// ---------------------------------------------
	AST_WAKE_HOLD: assert property (
		(!wake_event_i && !(csr_req_i.wr && hit_pwr && csr_req_i.wdata[PPB_WAKE_FLAG_BIT]))
		|=> $stable(state_reg.wake_flag))
		else $error("wake flag moved without event or clear");

	AST_WAKE_EN_TAKE: assert property (
		(csr_req_i.wr && hit_pwr)
		|=> state_reg.wake_en == $past(csr_req_i.wdata[PPB_WAKE_EN_BIT]))
		else $error("wake signal enable not written");

	AST_PME_ASSERT: assert property (
		(wake_event_i && state_reg.wake_en && !(csr_req_i.wr && hit_pwr)) |=> pme_oe_o)
		else $error("enabled wake event did not drive PME");

	AST_PSTATE_TAKE: assert property (
		(csr_req_i.wr && hit_pwr && PPB_PSTATE_SUPPORT[wr_state])
		|=> power_state_o == $past(wr_state))
		else $error("supported power state not taken");

	AST_PSTATE_HOLD: assert property (
		!(csr_req_i.wr && hit_pwr) |=> $stable(power_state_o))
		else $error("power state moved without a write");

	AST_PWR_READ: assert property (
		(csr_req_i.rd && hit_pwr)
		|=> csr_rdata_o == {16'h0000, $past(state_reg.wake_flag), 6'h00,
		$past(state_reg.wake_en), 6'h00, $past(power_state_o)})
		else $error("power word read wrong");

	// ---------------------------------------------
	// Burst checks
	// ---------------------------------------------
	AST_THRESH_TAKE: assert property (
		(csr_req_i.wr && hit_tx_burst_count_timeout)
		|=> state_reg.tb_thresh == $past(csr_req_i.wdata[PPB_TX_BURST_THRESHOLD_LSB +: PPB_TX_BURST_THRESHOLD_W]))
		else $error("burst threshold not written");

	AST_TX_BURST_COUNT_TIMEOUT_READ: assert property (
		(csr_req_i.rd && hit_tx_burst_count_timeout)
		|=> csr_rdata_o == {11'h000, $past(state_reg.tb_thresh), 16'h0000})
		else $error("burst word read wrong");

	AST_FAIL_RESTART: assert property (
		tx_evt_i.burst_fail |=> (state_reg.tb_count == 5'h00 && !tx_done_irq_o))
		else $error("failed burst did not restart the run");

	AST_TB_IDLE: assert property (
		(!tx_evt_i.burst_ok && !tx_evt_i.burst_fail)
		|=> ($stable(state_reg.tb_count) && !tx_done_irq_o))
		else $error("burst run moved without a burst");

	COV_PERF_READ: cover property (csr_req_i.rd && hit_perf && state_reg.clk_total != 16'h0000);
	COV_WAKE_PME: cover property (wake_event_i && state_reg.wake_en ##1 pme_oe_o);
	COV_TX_DONE: cover property (tx_done_irq_o);
	COV_PSTATE_D3: cover property (power_state_o == 2'h3);
	COV_BURST_RESTART: cover property (tx_evt_i.burst_fail && state_reg.tb_count != 5'h00);

endmodule

// ---- dv/ppb_bus_model.sv ----
// Far-side bus traffic model: one read access, then bus-master dwords
module ppb_bus_model
	import ppb_regs_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic go_i,
	input wire logic [7:0] gap_i,
	input wire logic [8:0] ndw_i,
	output ppb_regs_pkg::ppb_bus_evt_s evt_o,
	output logic busy_o
);
	timeunit 1ns;
	timeprecision 100ps;
	task automatic step();
		@(posedge clk_sys_i);
		#2;
	endtask
	// One process owns both outputs, so each has a single driver
	initial
	begin
		evt_o = '0;
		busy_o = 1'b0;
		// Only one access open at a time, so the next waits for go
		forever
		begin
			@(posedge go_i);
			busy_o = 1'b1;
			step();
			evt_o.rd_req = 1'b1;
			step();
			evt_o.rd_req = 1'b0;
			repeat (gap_i) step();
			evt_o.rd_done = 1'b1;
			step();
			evt_o.rd_done = 1'b0;
			evt_o.dword = (ndw_i != 9'h000);
			repeat (ndw_i) step();
			evt_o.dword = 1'b0;
			busy_o = 1'b0;
		end
	end
endmodule

// ---- dv/ppb_regs_bench.sv ----
// Self-checking bench of the performance, power and burst registers
module ppb_regs_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import ppb_regs_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	ppb_csr_req_s req = '0;
	ppb_tx_evt_s tx = '0;
	logic wake = 1'b0;
	logic go = 1'b0;
	logic [7:0] gap = 8'h00;
	logic [8:0] ndw = 9'h000;
	ppb_bus_evt_s evt;
	logic busy, ack, irq, pme_n, pme_oe;
	logic [31:0] rdata;
	logic [1:0] pstate;
	int num_errors = 0;
	int samples_checked = 0;
	int irq_cnt = 0;
	ppb_regs dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .csr_req_i(req), .bus_evt_i(evt),
		.tx_evt_i(tx), .wake_event_i(wake), .csr_rdata_o(rdata), .csr_ack_o(ack),
		.tx_done_irq_o(irq), .pme_n_o(pme_n), .pme_oe_o(pme_oe), .power_state_o(pstate));
	ppb_bus_model host (.clk_sys_i(clk_sys_i), .go_i(go), .gap_i(gap), .ndw_i(ndw),
		.evt_o(evt), .busy_o(busy));
	initial
	begin
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i)
	begin
		if (irq === 1'b1)
			irq_cnt++;
	end
	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic step();
		@(posedge clk_sys_i);
		#2;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		req.wr = 1'b1;
		req.addr = a;
		req.wdata = d;
		step();
		req.wr = 1'b0;
		step();
	endtask
	task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
		req.rd = 1'b1;
		req.addr = a;
		step();
		req.rd = 1'b0;
		// Ack stands for one cycle only, so look before the next edge
		chk("ack", {31'h0, ack}, 32'h1);
		chk(name, rdata, exp);
		step();
	endtask
	task automatic traffic(input logic [7:0] g, input logic [8:0] n);
		int t;
		gap = g;
		ndw = n;
		go = 1'b1;
		step();
		go = 1'b0;
		t = 0;
		while (busy !== 1'b0 && t < 1000)
		begin
			step();
			t++;
		end
	endtask
	task automatic burst(input logic ok, input logic fail);
		tx.burst_ok = ok;
		tx.burst_fail = fail;
		step();
		tx = '0;
		step();
	endtask
	task automatic wake_pulse();
		wake = 1'b1;
		step();
		wake = 1'b0;
		step();
	endtask
	task automatic final_report();
		$display("checked %0d, mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		repeat (2) @(posedge clk_sys_i);
		#2 rst_i = 1'b0;
		step();
		rd("perf rst", PPB_OFS_PERF, 32'h0);
		rd("tx_burst_count_timeout rst", PPB_OFS_TX_BURST_COUNT_TIMEOUT, 32'h0005_0000);
		rd("pwr rst", PPB_OFS_PWR, 32'h0);
		rd("unmapped", 8'h90, 32'h0);
		$display("test reset values done");
		traffic(8'h03, 9'h004);
		rd("perf", PPB_OFS_PERF, 32'h0005_0004);
		rd("perf clr", PPB_OFS_PERF, 32'h0);
		traffic(8'h00, 9'h12C);
		rd("perf sat", PPB_OFS_PERF, 32'h0002_00FF);
		$display("test performance counter done");
		wr(PPB_OFS_PWR, 32'h0000_0103);
		rd("d3hot", PPB_OFS_PWR, 32'h0000_0103);
		chk("state pin", {30'h0, pstate}, 32'h3);
		wr(PPB_OFS_PWR, 32'h0000_7F01);
		rd("d1 kept", PPB_OFS_PWR, 32'h0000_0103);
		wr(PPB_OFS_PWR, 32'h0000_0100);
		rd("d0", PPB_OFS_PWR, 32'h0000_0100);
		wake_pulse();
		rd("wake", PPB_OFS_PWR, 32'h0000_8100);
		chk("pme on", {30'h0, pme_oe, pme_n}, 32'h2);
		wr(PPB_OFS_PWR, 32'h0000_0100);
		rd("w0 kept", PPB_OFS_PWR, 32'h0000_8100);
		wr(PPB_OFS_PWR, 32'h0000_8100);
		rd("w1 clr", PPB_OFS_PWR, 32'h0000_0100);
		chk("pme off", {31'h0, pme_oe}, 32'h0);
		wr(PPB_OFS_PWR, 32'h0);
		wake_pulse();
		rd("wake dis", PPB_OFS_PWR, 32'h0000_8000);
		chk("pme masked", {31'h0, pme_oe}, 32'h0);
		$display("test power control done");
		// A failure mid-run must restart the count of good bursts
		repeat (4) burst(1'b1, 1'b0);
		burst(1'b0, 1'b1);
		repeat (4) burst(1'b1, 1'b0);
		chk("irq early", 32'(irq_cnt), 32'h0);
		burst(1'b1, 1'b0);
		chk("irq fifth", 32'(irq_cnt), 32'h1);
		wr(PPB_OFS_TX_BURST_COUNT_TIMEOUT, 32'hFFFF_FFFF);
		rd("tx_burst_count_timeout field", PPB_OFS_TX_BURST_COUNT_TIMEOUT, 32'h001F_0000);
		$display("test burst count done");
		final_report();
	end
	initial
	begin
		repeat (3000) @(posedge clk_sys_i);
		num_errors++;
		final_report();
	end
endmodule
